// [logic/tcac_ctrl.sv]
// activation control of the transfer controller: enables, software
// activation, block counter, module stop, register slave
//
// Function
// - 16-bit block counter, decrements per block, sequence ends at zero.
// - six 8-bit activation enables, zero on reset and hardware standby.
// - enabled interrupt activates the controller, otherwise goes to CPU.
// - enable bit clears if interrupt select set or count exhausted.
// - software activation register zero on reset and hardware standby.
// - software activation enable accepts only a written one.
// - vector number writable only while software activation enable is 0.
// - enable clears on plain end, or on 0 written after end request.
// - enable stays set while running, after select set, after exhaustion.
// - vector address is 0x0400 plus vector number shifted left one.
// - module stop bit 6 halts controller after current cycle.
// - writing 1 to the stop bit is refused while operating.
// - module stop register loads 0x3f on reset and hardware standby.
// - select 0 clears source flag unless count ends; select 1 keeps it.
// - chained transfers skip end checks until the last of the chain.
// - software end with select set or exhaustion raises end request.
`timescale 1ns/10ps
`default_nettype none
`include "tcac_params.svh"
module tcac_ctrl (
    input wire logic clk_i,              // 250 MHz system clock
    input wire logic rst_i,              // sync reset, high
    input wire logic hw_standby_i,       // hardware standby pin
    input wire logic [5:0] s_axi_awaddr,  // write address
    input wire logic s_axi_awvalid,      // write address valid
    output logic s_axi_awready,          // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb,  // byte enables
    input wire logic s_axi_wvalid,       // write data valid
    output logic s_axi_wready,           // write data ready
    output logic [1:0] s_axi_bresp,      // write response
    output logic s_axi_bvalid,           // write response valid
    input wire logic s_axi_bready,       // write response ready
    input wire logic [5:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid,      // read address valid
    output logic s_axi_arready,          // read address ready
    output logic [31:0] s_axi_rdata,     // read data
    output logic [1:0] s_axi_rresp,      // read response
    output logic s_axi_rvalid,           // read data valid
    input wire logic s_axi_rready,       // read data ready
    input wire logic [47:0] irq_req_i,   // source flags from irq ctrl
    input wire logic xfer_done_i,        // datapath: one block done
    input wire logic xfer_chain_i,       // chain_enable of that block
    input wire logic xfer_interrupt_select_i,       // interrupt_select of block
    output logic xfer_req_o,             // transfer under way
    output logic xfer_sw_o,              // current run is software
    output tcac_pkg::tcac_src_t xfer_src_o, // activating source
    output logic [15:0] xfer_vec_addr_o, // software vector address
    output logic [47:0] src_clear_o,     // pulse: clear source flag
    output logic [47:0] cpu_irq_o,       // requests routed to CPU
    output logic sw_end_irq_o,           // software transfer end irq
    output logic module_stopped_o        // module stop mode entered
);
    import tcac_pkg::*;

    // hardware standby passes two flops before use
    logic stby_s1;
    logic stby_s2;
    always_ff @(posedge clk_i)
    begin
        stby_s1 <= hw_standby_i;
        stby_s2 <= stby_s1;
    end
    wire clr = rst_i | stby_s2;

    // state
    tcac_state_t state;
    logic [47:0] act_en;
    logic swe;
    logic [6:0] vec;
    logic [7:0] msc;
    logic sw_end;
    logic [15:0] count;
    logic cnt_last;
    localparam logic [7:0] vec_rst = `TCAC_VEC_RST;

    // write channel: each ready drops once its item is held
    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs = s_axi_wvalid & s_axi_wready;
    wire b_hs = s_axi_bvalid & s_axi_bready;
    logic [5:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    wire do_wr = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

    // write decode, one aligned word per register
    wire [3:0] wr_idx = awaddr_q[5:2];
    wire wr_en_hit = do_wr & (wr_idx < 4'd6);
    wire wr_vec = do_wr & (awaddr_q == `TCAC_OFF_VEC);
    wire wr_msc = do_wr & (awaddr_q == `TCAC_OFF_MSC);
    wire wr_cnt = do_wr & (awaddr_q == `TCAC_OFF_CNT);
    wire wr_stat = do_wr & (awaddr_q == `TCAC_OFF_STAT);
    wire wr_ok = wr_en_hit | wr_vec | wr_msc | wr_cnt | wr_stat;
    wire b0 = wstrb_q[0];
    wire [7:0] wb0 = wdata_q[7:0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TCAC_RESP_OKAY;
            awaddr_q <= 6'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (aw_hs)
            begin
                s_axi_awready <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end
            if (w_hs)
            begin
                s_axi_wready <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            // unmapped addresses answer slverr
            if (do_wr)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `TCAC_RESP_OKAY : `TCAC_RESP_SLVERR;
            end
            else if (b_hs)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // vector address from the vector number
    wire [15:0] vec_addr = `TCAC_VEC_BASE + {8'h00, vec, 1'b0};

    // read decode
    wire [3:0] rd_idx = s_axi_araddr[5:2];
    wire [7:0] rd_en_byte = act_en[{rd_idx[2:0], 3'b000} +: 8];
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb
    begin
        rd_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        if (rd_idx < 4'd6)
            rd_mux = {24'h000000, rd_en_byte};
        else if (s_axi_araddr == `TCAC_OFF_VEC)
            rd_mux = {24'h000000, swe, vec};
        else if (s_axi_araddr == `TCAC_OFF_MSC)
            rd_mux = {24'h000000, msc};
        else if (s_axi_araddr == `TCAC_OFF_CNT)
            rd_mux = {16'h0000, count};
        else if (s_axi_araddr == `TCAC_OFF_STAT)
            rd_mux = {13'h0000, state == ST_RUN, module_stopped_o,
                      sw_end, vec_addr};
        else
            rd_ok = 1'b0;
    end

    // read channel, single outstanding
    wire ar_hs = s_axi_arvalid & s_axi_arready;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TCAC_RESP_OKAY;
        end
        else if (ar_hs)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? `TCAC_RESP_OKAY : `TCAC_RESP_SLVERR;
        end
        else if (s_axi_rvalid & s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // lowest enabled source wins, fixed default priority
    function automatic logic [5:0] pick_src(input logic [47:0] p);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 47; i >= 0; i--)
            if (p[i])
                r = 6'(i);
        return r;
    endfunction : pick_src

    wire stop = msc[`TCAC_STOP_BIT];
    // a flag being cleared this cycle must not start a second run
    wire [47:0] pend = irq_req_i & act_en & ~src_clear_o;
    wire idle = (state == ST_IDLE);
    wire start_int = idle & ~stop & (|pend);
    wire start_sw = idle & ~stop & ~(|pend) & swe & ~sw_end;
    wire [5:0] next_src = pick_src(pend);

    // end of a sequence; chained blocks carry no end actions
    wire run_end = (state == ST_RUN) & xfer_done_i & ~xfer_chain_i;
    wire exhausted = cnt_last;
    wire keep = ~xfer_interrupt_select_i & ~exhausted;
    wire int_end = run_end & ~xfer_sw_o;
    wire sw_fin = run_end & xfer_sw_o;

    // block counter
    wire [15:0] cnt_load = {wstrb_q[1] ? wdata_q[15:8] : count[15:8],
                            b0 ? wb0 : count[7:0]};
    tcac_blk_cnt u_cnt (
        .clk_i(clk_i),
        .rst_i(clr),
        .load_i(wr_cnt),
        .load_val_i(cnt_load),
        .dec_i((state == ST_RUN) & xfer_done_i),
        .count_o(count),
        .last_o(cnt_last)
    );

    // sequence state; a stop cannot land mid run since it is refused
    always_ff @(posedge clk_i)
    begin
        if (clr)
            state <= ST_IDLE;
        else if (start_int | start_sw)
            state <= ST_RUN;
        else if (run_end)
            state <= ST_IDLE;
    end

    // transfer request outputs
    always_ff @(posedge clk_i)
    begin
        if (clr)
        begin
            xfer_req_o <= 1'b0;
            xfer_sw_o <= 1'b0;
            xfer_src_o <= 6'h00;
            xfer_vec_addr_o <= 16'h0000;
        end
        else if (start_int | start_sw)
        begin
            xfer_req_o <= 1'b1;
            xfer_sw_o <= start_sw;
            xfer_src_o <= next_src;
            xfer_vec_addr_o <= vec_addr;
        end
        else if (run_end)
            xfer_req_o <= 1'b0;
    end

    // activation enables: hw clear, then software byte write on top
    logic [47:0] next_act_en;
    always_comb
    begin
        next_act_en = act_en;
        if (int_end & ~keep)
            next_act_en[xfer_src_o] = 1'b0;
        if (wr_en_hit & b0)
            next_act_en[{wr_idx[2:0], 3'b000} +: 8] = wb0;
    end
    always_ff @(posedge clk_i)
    begin
        if (clr)
            act_en <= {`TCAC_NUM_EN{`TCAC_EN_RST}};
        else
            act_en <= next_act_en;
    end

    // source flag clear and CPU routing
    always_ff @(posedge clk_i)
    begin
        if (clr)
        begin
            src_clear_o <= 48'h0000_0000_0000;
            cpu_irq_o <= 48'h0000_0000_0000;
        end
        else
        begin
            src_clear_o <= (int_end & keep) ? (48'h1 << xfer_src_o)
                                            : 48'h0;
            cpu_irq_o <= irq_req_i & ~act_en;
        end
    end

    // software activation register
    wire swe_clr_wr = wr_vec & b0 & ~wb0[`TCAC_SWE_BIT] & sw_end;
    always_ff @(posedge clk_i)
    begin
        if (clr)
        begin
            swe <= vec_rst[`TCAC_SWE_BIT];
            vec <= vec_rst[6:0];
        end
        else
        begin
            if (wr_vec & b0 & ~swe)
                vec <= wb0[6:0];
            if (wr_vec & b0 & wb0[`TCAC_SWE_BIT])
                swe <= 1'b1;
            else if ((sw_fin & keep) | swe_clr_wr)
                swe <= 1'b0;
        end
    end

    // software end request: the end event wins over a same-cycle clear
    always_ff @(posedge clk_i)
    begin
        if (clr)
            sw_end <= 1'b0;
        else if (sw_fin & ~keep)
            sw_end <= 1'b1;
        else if (swe_clr_wr)
            sw_end <= 1'b0;
    end
    assign sw_end_irq_o = sw_end;

    // module stop register; stop bit refused while a run is open
    wire stop_refuse = ~idle & wb0[`TCAC_STOP_BIT];
    always_ff @(posedge clk_i)
    begin
        if (clr)
            msc <= `TCAC_MSC_RST;
        else if (wr_msc & b0)
        begin
            msc <= wb0;
            if (stop_refuse)
                msc[`TCAC_STOP_BIT] <= msc[`TCAC_STOP_BIT];
        end
    end

    // stopped once idle with the stop bit set
    always_ff @(posedge clk_i)
    begin
        if (clr)
            module_stopped_o <= 1'b0;
        else
            module_stopped_o <= stop & idle;
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (clr);

    sequence s_int_end;
        int_end & ~keep;
    endsequence
    sequence s_sw_keep_end;
        sw_fin & ~keep;
    endsequence

    chk_reset_values: assert property (disable iff (1'b0)
        rst_i |=> msc == 8'h3f
        && act_en == 48'h0 && !swe && vec == 7'h00)
        else $error("reset values wrong");
    chk_count_dec: assert property ((state == ST_RUN) && xfer_done_i
        && !wr_cnt |=> count == $past(count) - 16'h0001)
        else $error("block counter did not decrement");
    chk_en_clear: assert property (s_int_end ##0 !wr_en_hit
        |=> !act_en[$past(xfer_src_o)])
        else $error("activation enable not cleared");
    chk_src_flag: assert property (int_end && keep
        |=> src_clear_o == (48'h1 << $past(xfer_src_o)))
        else $error("source flag clear missing");
    chk_chain_skip: assert property (xfer_done_i && xfer_chain_i
        && state == ST_RUN |=> state == ST_RUN && src_clear_o == 48'h0)
        else $error("chained block took end actions");
    chk_sw_end_req: assert property (s_sw_keep_end
        |=> sw_end_irq_o && swe && !xfer_req_o)
        else $error("software end request wrong");
    chk_swe_only_one: assert property ($rose(swe)
        |-> $past(wr_vec && b0 && wb0[7]))
        else $error("software enable set without write");
    chk_vec_locked: assert property ($past(swe) |-> $stable(vec))
        else $error("vector changed while enabled");
    chk_stop_refused: assert property (wr_msc && !idle
        && !msc[6] |=> !msc[6])
        else $error("stop accepted while operating");
    chk_vec_addr_out: assert property (start_sw
        |=> xfer_vec_addr_o == 16'h0400 + {8'h00, vec, 1'b0} ##1 xfer_sw_o)
        else $error("software vector address wrong");
    chk_cpu_route: assert property (##1 cpu_irq_o
        == ($past(irq_req_i) & ~$past(act_en)))
        else $error("interrupt routing wrong");
endmodule : tcac_ctrl
`default_nettype wire

// [logic/tcac_params.svh]
// offsets, field positions, reset values for the activation control block
`ifndef TCAC_PARAMS_SVH
`define TCAC_PARAMS_SVH

// register byte offsets (word index = offset / 4)
`define TCAC_OFF_EN0 6'h00
`define TCAC_OFF_VEC 6'h18
`define TCAC_OFF_MSC 6'h1c
`define TCAC_OFF_CNT 6'h20
`define TCAC_OFF_STAT 6'h24

// number of activation enable registers, number of sources
`define TCAC_NUM_EN 6
`define TCAC_NUM_SRC 48

// field positions
`define TCAC_SWE_BIT 7
`define TCAC_STOP_BIT 6

// reset values
`define TCAC_EN_RST 8'h00
`define TCAC_VEC_RST 8'h00
`define TCAC_MSC_RST 8'h3f
`define TCAC_CNT_RST 16'h0000

// software vector table base
`define TCAC_VEC_BASE 16'h0400

// bus answers
`define TCAC_RESP_OKAY 2'b00
`define TCAC_RESP_SLVERR 2'b10

`endif

// [logic/tcac_pkg.sv]
// types shared by the activation control block
`default_nettype none
package tcac_pkg;
    typedef enum logic {ST_IDLE, ST_RUN} tcac_state_t;
    typedef logic [5:0] tcac_src_t;
endpackage : tcac_pkg
`default_nettype wire

// [logic/tcac_blk_cnt.sv]
// block transfer down counter with byte-wise software load
`timescale 1ns/10ps
`default_nettype none
`include "tcac_params.svh"
module tcac_blk_cnt (
    input wire logic clk_i,          // system clock
    input wire logic rst_i,          // sync reset, high
    input wire logic load_i,         // software load strobe
    input wire logic [15:0] load_val_i, // merged load value
    input wire logic dec_i,          // one block finished
    output logic [15:0] count_o,     // current count
    output logic last_o              // count is one
);
    // zero means 65536 blocks; wraps to ffff on the first block
    assign last_o = (count_o == 16'h0001);

    // software load wins over a decrement in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            count_o <= `TCAC_CNT_RST;
        else if (load_i)
            count_o <= load_val_i;
        else if (dec_i)
            count_o <= count_o - 16'h0001;
    end
endmodule : tcac_blk_cnt
`default_nettype wire

// [tb/tcac_partner.sv]
// far-side model: interrupt source flags and block datapath
`timescale 1ns/10ps
`default_nettype none
module tcac_partner (
    input wire logic clk_i,          // system clock
    input wire logic rst_i,          // sync reset, high
    input wire logic xfer_req_i,     // transfer under way
    input wire logic [47:0] clr_i,   // device clears a flag
    input wire logic [47:0] raise_i, // source raises a flag
    input wire logic [47:0] ack_i,   // cpu services a flag
    input wire logic [4:0] gap_i,    // idle cycles per block
    output logic [47:0] flags_o,     // source flags, level
    output logic done_o              // block finished pulse
);
    logic [4:0] cnt;
    // flags hold until the device or the cpu clears them
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            flags_o <= '0;
        else
            flags_o <= (flags_o | raise_i) & ~(clr_i | ack_i);
    end
    // never back to back, so a late end cannot see a stray block
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !xfer_req_i || done_o)
        begin
            cnt <= '0;
            done_o <= 1'b0;
        end
        else if (cnt == gap_i)
        begin
            cnt <= '0;
            done_o <= 1'b1;
        end
        else
            cnt <= cnt + 5'h01;
    end
endmodule : tcac_partner
`default_nettype wire

// [tb/tcac_ctrl_test.sv]
// self-checking bench of the activation control block
`timescale 1ns/10ps
`default_nettype none
`include "tcac_params.svh"
`define CHK(nm, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("mismatch %s exp %h got %h", nm, e, g); \
        end \
    end
module tcac_ctrl_test;
    import tcac_pkg::*;
    localparam logic [5:0] en0_a = `TCAC_OFF_EN0;
    localparam logic [5:0] vec_a = `TCAC_OFF_VEC;
    localparam logic [5:0] msc_a = `TCAC_OFF_MSC;
    localparam logic [5:0] cnt_a = `TCAC_OFF_CNT;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hw_standby_i = 1'b0;
    logic [5:0] s_axi_awaddr = '0;
    logic [5:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [47:0] irq_req_i, src_clear_o, cpu_irq_o;
    logic [47:0] raise = '0;
    logic [47:0] ack = '0;
    logic xfer_done_i;
    logic xfer_chain_i = 1'b0;
    logic xfer_interrupt_select_i = 1'b0;
    logic xfer_req_o, xfer_sw_o, sw_end_irq_o, module_stopped_o;
    tcac_src_t xfer_src_o;
    logic [15:0] xfer_vec_addr_o;
    logic [4:0] gap = 5'h02;
    logic [31:0] d;
    logic [1:0] r;
    int mismatches = 0;
    int total_checks = 0;

    tcac_ctrl dut (
        .clk_i, .rst_i, .hw_standby_i,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .irq_req_i, .xfer_done_i, .xfer_chain_i, .xfer_interrupt_select_i,
        .xfer_req_o, .xfer_sw_o, .xfer_src_o, .xfer_vec_addr_o,
        .src_clear_o, .cpu_irq_o, .sw_end_irq_o, .module_stopped_o
    );
    tcac_partner far_end (
        .clk_i(clk_i), .rst_i(rst_i), .xfer_req_i(xfer_req_o),
        .clr_i(src_clear_o), .raise_i(raise), .ack_i(ack),
        .gap_i(gap), .flags_o(irq_req_i), .done_o(xfer_done_i)
    );

    // 250 MHz system clock
    always #2 clk_i = ~clk_i;

    task automatic give_verdict;
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    task automatic hang;
        mismatches++;
        $display("mismatch wait exp event got timeout");
        give_verdict;
    endtask : hang

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        repeat (40)
        begin
            @(posedge clk_i);
            if (s_axi_bvalid)
            begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
            if (!aw && s_axi_awready)
            begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready)
            begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        hang;
    endtask : wr

    task automatic rd(input logic [5:0] a);
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        repeat (40)
        begin
            @(posedge clk_i);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        hang;
    endtask : rd

    task automatic chk_rd(input logic [5:0] a, input logic [31:0] e,
                          input string nm);
        rd(a);
        `CHK(nm, e, d)
    endtask : chk_rd

    // 0: run starts, 1: run over, 2: a block finishes
    task automatic wait_for(input int k);
        repeat (100)
        begin
            @(posedge clk_i);
            if ((k == 0 && xfer_req_o) || (k == 1 && !xfer_req_o)
                || (k == 2 && xfer_done_i))
                return;
        end
        hang;
    endtask : wait_for

    task automatic src_ev(input logic [47:0] up, input logic [47:0] dn);
        @(posedge clk_i);
        raise <= up;
        ack <= dn;
        @(posedge clk_i);
        raise <= '0;
        ack <= '0;
    endtask : src_ev

    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset contents and unmapped places
        for (int i = 0; i < 6; i++)
            chk_rd(6'(i * 4), 32'h0, "enable");
        chk_rd(vec_a, 32'h0, "vector");
        chk_rd(msc_a, 32'h3f, "stop");
        rd(6'h28);
        `CHK("rresp", `TCAC_RESP_SLVERR, r)
        wr(6'h2c, 32'h1);
        `CHK("bresp", `TCAC_RESP_SLVERR, r)
        // plain run: flag cleared, enable kept, count down by one
        wr(cnt_a, 32'h3);
        rd(en0_a);
        wr(en0_a, d | 32'h4);
        src_ev(48'h4, '0);
        wait_for(0);
        `CHK("source", 6'h02, xfer_src_o)
        wait_for(1);
        repeat (2) @(posedge clk_i);
        `CHK("flag2", 1'b0, irq_req_i[2])
        chk_rd(en0_a, 32'h4, "enable0");
        chk_rd(cnt_a, 32'h2, "count");
        // last block: enable cleared, request passed to the cpu
        wr(cnt_a, 32'h1);
        src_ev(48'h4, '0);
        wait_for(0);
        wait_for(1);
        repeat (2) @(posedge clk_i);
        `CHK("flag2", 1'b1, irq_req_i[2])
        `CHK("cpu2", 1'b1, cpu_irq_o[2])
        chk_rd(en0_a, 32'h0, "enable0");
        chk_rd(cnt_a, 32'h0, "count");
        src_ev('0, 48'h4);
        // select set: enable cleared though blocks remain
        xfer_interrupt_select_i <= 1'b1;
        wr(cnt_a, 32'h5);
        wr(en0_a + 6'h04, 32'h1);
        src_ev(48'h100, '0);
        wait_for(0);
        wait_for(1);
        repeat (2) @(posedge clk_i);
        `CHK("flag8", 1'b1, irq_req_i[8])
        chk_rd(en0_a + 6'h04, 32'h0, "enable1");
        chk_rd(cnt_a, 32'h4, "count");
        src_ev('0, 48'h100);
        // chain: no end actions until the last block
        xfer_interrupt_select_i <= 1'b0;
        xfer_chain_i <= 1'b1;
        gap <= 5'h06;
        wr(en0_a + 6'h04, 32'h2);
        src_ev(48'h200, '0);
        wait_for(2);
        xfer_chain_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        `CHK("flag9", 1'b1, irq_req_i[9])
        `CHK("busy", 1'b1, xfer_req_o)
        wait_for(1);
        repeat (2) @(posedge clk_i);
        `CHK("flag9", 1'b0, irq_req_i[9])
        // software run, plain end clears the enable
        gap <= 5'h1e;
        wr(cnt_a, 32'ha);
        wr(vec_a, 32'h90);
        wait_for(0);
        `CHK("vaddr", 16'h0420, xfer_vec_addr_o)
        `CHK("sw", 1'b1, xfer_sw_o)
        chk_rd(6'h24, 32'h0004_0420, "status");
        chk_rd(vec_a, 32'h90, "vector");
        wait_for(1);
        repeat (2) @(posedge clk_i);
        chk_rd(vec_a, 32'h10, "vector");
        wr(vec_a, 32'h05);
        chk_rd(vec_a, 32'h05, "vector");
        // select set: enable held, end request raised
        xfer_interrupt_select_i <= 1'b1;
        wr(vec_a, 32'h85);
        wait_for(0);
        wr(vec_a, 32'h07);
        chk_rd(vec_a, 32'h85, "vector");
        wr(msc_a, 32'h7f);
        chk_rd(msc_a, 32'h3f, "stop");
        wait_for(1);
        repeat (2) @(posedge clk_i);
        `CHK("swend", 1'b1, sw_end_irq_o)
        chk_rd(vec_a, 32'h85, "vector");
        wr(vec_a, 32'h0);
        chk_rd(vec_a, 32'h05, "vector");
        `CHK("swend", 1'b0, sw_end_irq_o)
        xfer_interrupt_select_i <= 1'b0;
        // module stop holds off a pending source
        gap <= 5'h02;
        wr(msc_a, 32'h7f);
        chk_rd(msc_a, 32'h7f, "stop");
        repeat (2) @(posedge clk_i);
        `CHK("stopped", 1'b1, module_stopped_o)
        wr(en0_a + 6'h08, 32'h1);
        src_ev(48'h10000, '0);
        repeat (10) @(posedge clk_i);
        `CHK("busy", 1'b0, xfer_req_o)
        wr(msc_a, 32'h3f);
        wait_for(0);
        wait_for(1);
        `CHK("stopped", 1'b0, module_stopped_o)
        // hardware standby restores the reset contents
        wr(en0_a, 32'hff);
        wr(vec_a, 32'h22);
        wr(msc_a, 32'h7f);
        hw_standby_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        hw_standby_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk_rd(en0_a, 32'h0, "enable0");
        chk_rd(vec_a, 32'h0, "vector");
        chk_rd(msc_a, 32'h3f, "stop");
        give_verdict;
    end
endmodule : tcac_ctrl_test
`default_nettype wire
